/* File: timing_port_map.svh */
// Purpose: Offsets, field positions, reset values and limits of the port dataset store.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Definitions only.
`ifndef TIMING_PORT_MAP_SVH
`define TIMING_PORT_MAP_SVH

// Register byte offsets.
`define TP_OFF_CONFIG 8'h00
`define TP_OFF_PRESET_TX_LO 8'h04
`define TP_OFF_PRESET_TX_HI 8'h08
`define TP_OFF_PRESET_RX_LO 8'h0C
`define TP_OFF_PRESET_RX_HI 8'h10
`define TP_OFF_STATE_TIMEOUT 8'h14
`define TP_OFF_STATE_RETRY 8'h18
`define TP_OFF_CAL_PERIOD 8'h1C
`define TP_OFF_CAL_RETRY 8'h20
`define TP_OFF_STATUS 8'h24
`define TP_OFF_LINK_STATE 8'h28
`define TP_OFF_ROLE 8'h2C
`define TP_OFF_MEAS_TX_LO 8'h30
`define TP_OFF_MEAS_TX_HI 8'h34
`define TP_OFF_MEAS_RX_LO 8'h38
`define TP_OFF_MEAS_RX_HI 8'h3C
`define TP_OFF_PART_TX_LO 8'h40
`define TP_OFF_PART_TX_HI 8'h44
`define TP_OFF_PART_RX_LO 8'h48
`define TP_OFF_PART_RX_HI 8'h4C
`define TP_OFF_PART_PERIOD 8'h50
`define TP_OFF_PART_RETRY 8'h54
`define TP_OFF_FLAGS 8'h58
`define TP_OFF_PRIMARY 8'h5C
`define TP_OFF_EVENT 8'h60

// Event register bit positions (write one to fire).
`define TP_EV_REINIT 0
`define TP_EV_RETRIES 1
`define TP_EV_LINK_LOST 2
`define TP_EV_ANNOUNCE_TO 3
`define TP_EV_MODE_OFF 4
`define TP_EV_LEAVE_SLAVE 5
`define TP_EV_LINK_ON 6
`define TP_EV_LOAD_DEFAULTS 7

// Static defaults and limits.
`define TP_PORT_NUMBER 8'h01
`define TP_DEF_CAL_PERIOD_US 32'h00000BB8
`define TP_DEF_CAL_RETRY (`TP_PORT_NUMBER + 8'h02)
`define TP_DEF_STATE_TIMEOUT_MS 32'h000003E8
`define TP_DEF_STATE_RETRY 8'h03
`define TP_MAX_CAL_RETRY 8'h20
`define TP_ANNOUNCE_INTERVAL_US 32'h001E8480
`define TP_DELAY_ZERO 64'h0000000000000000

`endif

/* File: timing_port_pkg.sv */
// Purpose: Types of the port dataset store.
// Assumes: Zero codes mean disabled or idle.
// Notes: Constants live in timing_port_map.svh.
package timing_port_pkg;

	// Configured role of the port.
	typedef enum logic [1:0] {
		CFG_DISABLED = 2'h0,
		CFG_SLAVE_ONLY = 2'h1,
		CFG_MASTER_ONLY = 2'h2,
		CFG_MASTER_AND_SLAVE = 2'h3
	} role_config_e;

	// Current or parent role.
	typedef enum logic [1:0] {
		ROLE_DISABLED = 2'h0,
		ROLE_SLAVE = 2'h1,
		ROLE_MASTER = 2'h2
	} port_role_e;

	// Link-setup states as stored by the protocol engine.
	typedef enum logic [3:0] {
		LS_IDLE = 4'h0,
		LS_PRESENT = 4'h1,
		LS_M_LOCK = 4'h2,
		LS_S_LOCK = 4'h3,
		LS_LOCKED = 4'h4,
		LS_CALIBRATION = 4'h5,
		LS_CALIBRATED = 4'h6,
		LS_RESP_CALIB_REQ = 4'h7,
		LS_LINK_ON = 4'h8
	} link_state_e;

	// Fixed delay in picoseconds times two to the sixteenth.
	typedef logic [63:0] delay_t;

endpackage : timing_port_pkg

/* File: timing_port_dataset_store.sv */
// Purpose: Per-port store of the link-setup dataset fields, reached over APB.
// Assumes: One clock mclk at 100 MHz; APB master keeps the standard protocol.
// Notes: Every access answers with one wait state; events are fired through the event register.
`include "timing_port_map.svh"

// Functional notes
// - All fields valid straight out of reset.
// - Static fields load configured or default values.
// - Leaving idle restores dynamic fields.
// - Current role survives leaving idle.
// - Retries-exhausted event restores dynamic fields.
// - Delay fields are 64-bit scaled picoseconds.
// - Calibration retry limit never exceeds 32.
// - Calibration period stays below announce interval.
// - Four role configs, default master and slave.
// - Default calibration period is 3000 us.
// - Default calibration retries equal port plus two.
// - State timeout 32-bit, default 1000 ms.
// - State retry limit 8-bit, default 3.
// - Preset flag false, preset delays zero.
// - Init copies preset values into measured ones.
// - Partner and parent values init zero/false.
// - Primary follower port 16-bit, init zero.
// - Link state idle, active flag false.
// - Roles and parent config init disabled.
// - Active flag set on completion, cleared by mode off, leaving slave, link loss and dynamic restores.
// - Role disabled on link loss, and on announce timeout when slave.
module timing_port_dataset_store import timing_port_pkg::*; (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rstn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Live view for the protocol engine.
	output logic [1:0] currentPortRole,
	output logic roleActiveFlag,
	output logic [3:0] linkSetupState
);

	// Whole register state of the block.
	typedef struct packed {
		role_config_e portRoleConfig;
		delay_t presetTxDelay;
		delay_t presetRxDelay;
		logic delaysPresetFlag;
		logic [31:0] stateTimeout;
		logic [7:0] stateRetryLimit;
		logic [31:0] calibrationPeriod;
		logic [7:0] calibrationRetryLimit;
		port_role_e currentPortRole;
		logic roleActiveFlag;
		link_state_e linkSetupState;
		logic calibratedFlag;
		delay_t measuredTxDelay;
		delay_t measuredRxDelay;
		role_config_e parentRoleConfig;
		port_role_e parentRole;
		logic parentRoleActive;
		logic parentCalibratedFlag;
		delay_t partnerTxDelay;
		delay_t partnerRxDelay;
		logic [31:0] partnerCalibrationPeriod;
		logic [7:0] partnerCalibrationRetries;
		logic partnerPatternRequest;
		logic [15:0] primaryFollowerPort;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_s;

	// Reset image; every dynamic enumeration starts at its zero code.
	localparam state_s STATE_RST = '{
		portRoleConfig: CFG_MASTER_AND_SLAVE,
		presetTxDelay: `TP_DELAY_ZERO,
		presetRxDelay: `TP_DELAY_ZERO,
		delaysPresetFlag: 1'b0,
		stateTimeout: `TP_DEF_STATE_TIMEOUT_MS,
		stateRetryLimit: `TP_DEF_STATE_RETRY,
		calibrationPeriod: `TP_DEF_CAL_PERIOD_US,
		calibrationRetryLimit: `TP_DEF_CAL_RETRY,
		currentPortRole: ROLE_DISABLED,
		roleActiveFlag: 1'b0,
		linkSetupState: LS_IDLE,
		calibratedFlag: 1'b0,
		measuredTxDelay: `TP_DELAY_ZERO,
		measuredRxDelay: `TP_DELAY_ZERO,
		parentRoleConfig: CFG_DISABLED,
		parentRole: ROLE_DISABLED,
		parentRoleActive: 1'b0,
		parentCalibratedFlag: 1'b0,
		partnerTxDelay: `TP_DELAY_ZERO,
		partnerRxDelay: `TP_DELAY_ZERO,
		partnerCalibrationPeriod: 32'h00000000,
		partnerCalibrationRetries: 8'h00,
		partnerPatternRequest: 1'b0,
		primaryFollowerPort: 16'h0000,
		pready: 1'b0,
		pslverr: 1'b0,
		prdata: 32'h00000000
	};

	logic rstMeta;
	logic rstSyncN;
	state_s stateReg;
	state_s stateNext;
	logic accessPhase;
	logic commit;
	logic wrCommit;
	logic [7:0] eventBits;

	// Reset release through two flops; assertion stays asynchronous.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rstMeta <= 1'b0;
			rstSyncN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSyncN <= rstMeta;
		end
	end

	// A write lands only at the edge where pready is already high.
	assign accessPhase = psel & penable;
	assign commit = accessPhase & stateReg.pready;
	assign wrCommit = commit & pwrite;
	assign eventBits = (wrCommit && paddr == `TP_OFF_EVENT) ? pwdata[7:0] : 8'h00;

	// Restore dynamic fields; the current role is optionally kept.
	function automatic state_s dynInit(input state_s s, input logic keepRole);
		state_s t;
		t = s;
		if (!keepRole) begin
			t.currentPortRole = ROLE_DISABLED;
		end
		t.roleActiveFlag = 1'b0;
		t.linkSetupState = LS_IDLE;
		t.calibratedFlag = s.delaysPresetFlag;
		t.measuredTxDelay = s.presetTxDelay;
		t.measuredRxDelay = s.presetRxDelay;
		t.parentRoleConfig = CFG_DISABLED;
		t.parentRole = ROLE_DISABLED;
		t.parentRoleActive = 1'b0;
		t.parentCalibratedFlag = 1'b0;
		t.partnerTxDelay = `TP_DELAY_ZERO;
		t.partnerRxDelay = `TP_DELAY_ZERO;
		t.partnerCalibrationPeriod = 32'h00000000;
		t.partnerCalibrationRetries = 8'h00;
		t.partnerPatternRequest = 1'b0;
		t.primaryFollowerPort = 16'h0000;
		return t;
	endfunction : dynInit

	// Next state: APB answer, field writes, then events in priority order.
	always_comb begin
		logic [31:0] rdVal;
		logic hit;
		logic [31:0] periodMax;
		rdVal = 32'h00000000;
		hit = 1'b1;
		periodMax = `TP_ANNOUNCE_INTERVAL_US - 32'h00000001;
		stateNext = stateReg;
		stateNext.pready = 1'b0;
		stateNext.pslverr = 1'b0;
		unique case (paddr)
			`TP_OFF_CONFIG: rdVal = {29'h00000000, stateReg.delaysPresetFlag, stateReg.portRoleConfig};
			`TP_OFF_PRESET_TX_LO: rdVal = stateReg.presetTxDelay[31:0];
			`TP_OFF_PRESET_TX_HI: rdVal = stateReg.presetTxDelay[63:32];
			`TP_OFF_PRESET_RX_LO: rdVal = stateReg.presetRxDelay[31:0];
			`TP_OFF_PRESET_RX_HI: rdVal = stateReg.presetRxDelay[63:32];
			`TP_OFF_STATE_TIMEOUT: rdVal = stateReg.stateTimeout;
			`TP_OFF_STATE_RETRY: rdVal = {24'h000000, stateReg.stateRetryLimit};
			`TP_OFF_CAL_PERIOD: rdVal = stateReg.calibrationPeriod;
			`TP_OFF_CAL_RETRY: rdVal = {24'h000000, stateReg.calibrationRetryLimit};
			`TP_OFF_STATUS: rdVal = {23'h000000, stateReg.calibratedFlag, stateReg.linkSetupState,
				1'b0, stateReg.roleActiveFlag, stateReg.currentPortRole};
			`TP_OFF_LINK_STATE: rdVal = {28'h0000000, stateReg.linkSetupState};
			`TP_OFF_ROLE: rdVal = {30'h00000000, stateReg.currentPortRole};
			`TP_OFF_MEAS_TX_LO: rdVal = stateReg.measuredTxDelay[31:0];
			`TP_OFF_MEAS_TX_HI: rdVal = stateReg.measuredTxDelay[63:32];
			`TP_OFF_MEAS_RX_LO: rdVal = stateReg.measuredRxDelay[31:0];
			`TP_OFF_MEAS_RX_HI: rdVal = stateReg.measuredRxDelay[63:32];
			`TP_OFF_PART_TX_LO: rdVal = stateReg.partnerTxDelay[31:0];
			`TP_OFF_PART_TX_HI: rdVal = stateReg.partnerTxDelay[63:32];
			`TP_OFF_PART_RX_LO: rdVal = stateReg.partnerRxDelay[31:0];
			`TP_OFF_PART_RX_HI: rdVal = stateReg.partnerRxDelay[63:32];
			`TP_OFF_PART_PERIOD: rdVal = stateReg.partnerCalibrationPeriod;
			`TP_OFF_PART_RETRY: rdVal = {24'h000000, stateReg.partnerCalibrationRetries};
			`TP_OFF_FLAGS: rdVal = {24'h000000, stateReg.parentRole, stateReg.parentRoleConfig,
				stateReg.calibratedFlag, stateReg.parentCalibratedFlag,
				stateReg.parentRoleActive, stateReg.partnerPatternRequest};
			`TP_OFF_PRIMARY: rdVal = {16'h0000, stateReg.primaryFollowerPort};
			`TP_OFF_EVENT: rdVal = 32'h00000000;
			default: hit = 1'b0;
		endcase
		// First access cycle prepares the answer; pready rises one edge later.
		if (accessPhase && !stateReg.pready) begin
			stateNext.pready = 1'b1;
			stateNext.prdata = pwrite ? 32'h00000000 : rdVal;
			stateNext.pslverr = ~hit;
		end
		// Field writes; clamps keep the static limits in range whatever software asks.
		if (wrCommit) begin
			unique case (paddr)
				`TP_OFF_CONFIG: begin
					stateNext.portRoleConfig = role_config_e'(pwdata[1:0]);
					stateNext.delaysPresetFlag = pwdata[2];
				end
				`TP_OFF_PRESET_TX_LO: stateNext.presetTxDelay[31:0] = pwdata;
				`TP_OFF_PRESET_TX_HI: stateNext.presetTxDelay[63:32] = pwdata;
				`TP_OFF_PRESET_RX_LO: stateNext.presetRxDelay[31:0] = pwdata;
				`TP_OFF_PRESET_RX_HI: stateNext.presetRxDelay[63:32] = pwdata;
				`TP_OFF_STATE_TIMEOUT: stateNext.stateTimeout = pwdata;
				`TP_OFF_STATE_RETRY: stateNext.stateRetryLimit = pwdata[7:0];
				`TP_OFF_CAL_PERIOD: stateNext.calibrationPeriod =
					(pwdata > periodMax) ? periodMax : pwdata;
				`TP_OFF_CAL_RETRY: stateNext.calibrationRetryLimit =
					(pwdata > {24'h000000, `TP_MAX_CAL_RETRY}) ? `TP_MAX_CAL_RETRY : pwdata[7:0];
				`TP_OFF_LINK_STATE: begin
					// Leaving idle wipes dynamic fields but the role, then takes the new state.
					if (stateReg.linkSetupState == LS_IDLE && pwdata[3:0] != 4'h0) begin
						stateNext = dynInit(stateNext, 1'b1);
					end
					stateNext.linkSetupState = link_state_e'(pwdata[3:0]);
				end
				`TP_OFF_ROLE: stateNext.currentPortRole = port_role_e'(pwdata[1:0]);
				`TP_OFF_MEAS_TX_LO: stateNext.measuredTxDelay[31:0] = pwdata;
				`TP_OFF_MEAS_TX_HI: stateNext.measuredTxDelay[63:32] = pwdata;
				`TP_OFF_MEAS_RX_LO: stateNext.measuredRxDelay[31:0] = pwdata;
				`TP_OFF_MEAS_RX_HI: stateNext.measuredRxDelay[63:32] = pwdata;
				`TP_OFF_PART_TX_LO: stateNext.partnerTxDelay[31:0] = pwdata;
				`TP_OFF_PART_TX_HI: stateNext.partnerTxDelay[63:32] = pwdata;
				`TP_OFF_PART_RX_LO: stateNext.partnerRxDelay[31:0] = pwdata;
				`TP_OFF_PART_RX_HI: stateNext.partnerRxDelay[63:32] = pwdata;
				`TP_OFF_PART_PERIOD: stateNext.partnerCalibrationPeriod = pwdata;
				`TP_OFF_PART_RETRY: stateNext.partnerCalibrationRetries = pwdata[7:0];
				`TP_OFF_FLAGS: begin
					stateNext.partnerPatternRequest = pwdata[0];
					stateNext.parentRoleActive = pwdata[1];
					stateNext.parentCalibratedFlag = pwdata[2];
					stateNext.calibratedFlag = pwdata[3];
					stateNext.parentRoleConfig = role_config_e'(pwdata[5:4]);
					stateNext.parentRole = port_role_e'(pwdata[7:6]);
				end
				`TP_OFF_PRIMARY: stateNext.primaryFollowerPort = pwdata[15:0];
				default: stateNext.pready = stateNext.pready;
			endcase
		end
		// Completion raises the active flag; on a slave the parent is live as well.
		// A jump straight out of idle still leaves idle, so the dynamic fields are wiped first.
		if (eventBits[`TP_EV_LINK_ON]) begin
			if (stateReg.linkSetupState == LS_IDLE) begin
				stateNext = dynInit(stateNext, 1'b1);
			end
			stateNext.roleActiveFlag = 1'b1;
			stateNext.linkSetupState = LS_LINK_ON;
			if (stateReg.currentPortRole == ROLE_SLAVE) begin
				stateNext.parentRoleActive = 1'b1;
			end
		end
		// Clearing events come later so they win over a completion in the same write.
		if (eventBits[`TP_EV_MODE_OFF] || eventBits[`TP_EV_LEAVE_SLAVE]) begin
			stateNext.roleActiveFlag = 1'b0;
		end
		if (eventBits[`TP_EV_LINK_LOST]) begin
			stateNext.roleActiveFlag = 1'b0;
			stateNext.currentPortRole = ROLE_DISABLED;
		end
		if (eventBits[`TP_EV_ANNOUNCE_TO] && stateReg.currentPortRole == ROLE_SLAVE) begin
			stateNext.currentPortRole = ROLE_DISABLED;
		end
		// Static defaults reload, then a full dynamic restore if asked.
		if (eventBits[`TP_EV_LOAD_DEFAULTS]) begin
			stateNext.portRoleConfig = STATE_RST.portRoleConfig;
			stateNext.delaysPresetFlag = STATE_RST.delaysPresetFlag;
			stateNext.presetTxDelay = STATE_RST.presetTxDelay;
			stateNext.presetRxDelay = STATE_RST.presetRxDelay;
			stateNext.stateTimeout = STATE_RST.stateTimeout;
			stateNext.stateRetryLimit = STATE_RST.stateRetryLimit;
			stateNext.calibrationPeriod = STATE_RST.calibrationPeriod;
			stateNext.calibrationRetryLimit = STATE_RST.calibrationRetryLimit;
		end
		if (eventBits[`TP_EV_RETRIES] || eventBits[`TP_EV_REINIT]) begin
			stateNext = dynInit(stateNext, 1'b0);
		end
	end

	// Single state register; the reset image is valid before any protocol use.
	always_ff @(posedge mclk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			stateReg <= STATE_RST;
		end else begin
			stateReg <= stateNext;
		end
	end

	// Outputs straight from the state flops.
	assign prdata = stateReg.prdata;
	assign pready = stateReg.pready;
	assign pslverr = stateReg.pslverr;
	assign currentPortRole = stateReg.currentPortRole;
	assign roleActiveFlag = stateReg.roleActiveFlag;
	assign linkSetupState = stateReg.linkSetupState;

	// Checks on the stored fields and the bus answer.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstSyncN);

	chk_retry_limit_bound: assert property (stateReg.calibrationRetryLimit <= 8'h20)
		else $error("Calibration retry limit above 32.");

	chk_period_below_announce: assert property (stateReg.calibrationPeriod < `TP_ANNOUNCE_INTERVAL_US)
		else $error("Calibration period not below announce interval.");

	chk_idle_exit_keep: assert property (
		(wrCommit && paddr == `TP_OFF_LINK_STATE && stateReg.linkSetupState == LS_IDLE
			&& pwdata[3:0] != 4'h0)
		|=> (stateReg.currentPortRole == $past(stateReg.currentPortRole)
			&& stateReg.partnerTxDelay == 64'h0 && !stateReg.roleActiveFlag
			&& stateReg.measuredRxDelay == stateReg.presetRxDelay))
		else $error("Leaving idle did not restore dynamic fields correctly.");

	chk_retries_restore: assert property (
		eventBits[`TP_EV_RETRIES]
		|=> (stateReg.linkSetupState == LS_IDLE && stateReg.currentPortRole == ROLE_DISABLED
			&& stateReg.primaryFollowerPort == 16'h0000 && stateReg.partnerCalibrationRetries == 8'h00))
		else $error("Retries exhausted did not restore dynamic fields.");

	chk_link_lost_role: assert property (
		eventBits[`TP_EV_LINK_LOST] |=> (stateReg.currentPortRole == ROLE_DISABLED && !stateReg.roleActiveFlag))
		else $error("Link loss left a role or active flag set.");

	chk_link_on_active: assert property (
		(eventBits[6:0] == 7'h40) |=> stateReg.roleActiveFlag ##1 (stateReg.roleActiveFlag || $past(commit)))
		else $error("Completion did not raise the active flag.");

	chk_calibrated_copy: assert property (
		eventBits[`TP_EV_REINIT] |=> (stateReg.calibratedFlag == stateReg.delaysPresetFlag
			&& stateReg.measuredTxDelay == stateReg.presetTxDelay))
		else $error("Init did not copy preset values.");

	chk_apb_wait_state: assert property (
		(accessPhase && !pready) |=> pready ##1 !pready)
		else $error("APB answer not exactly one wait state.");

	// Whatever path leaves idle, the dynamic fields must be clean in the first cycle out.
	chk_idle_leave_wipe: assert property (
		(stateReg.linkSetupState == LS_IDLE ##1 stateReg.linkSetupState != LS_IDLE)
		|-> (stateReg.partnerTxDelay == `TP_DELAY_ZERO && stateReg.partnerCalibrationPeriod == 32'h00000000
			&& stateReg.primaryFollowerPort == 16'h0000 && stateReg.calibratedFlag == stateReg.delaysPresetFlag
			&& stateReg.measuredTxDelay == stateReg.presetTxDelay))
		else $error("Leaving idle left a dynamic field dirty.");

	chk_mode_off_clear: assert property (
		(eventBits[`TP_EV_MODE_OFF] || eventBits[`TP_EV_LEAVE_SLAVE]) |=> !stateReg.roleActiveFlag)
		else $error("Mode off or leaving slave kept the active flag.");

	chk_announce_role_drop: assert property (
		(eventBits[`TP_EV_ANNOUNCE_TO] && stateReg.currentPortRole == ROLE_SLAVE)
		|=> (stateReg.currentPortRole == ROLE_DISABLED))
		else $error("Announce timeout left the slave role set.");

	chk_static_defaults: assert property (
		eventBits[`TP_EV_LOAD_DEFAULTS]
		|=> (stateReg.portRoleConfig == CFG_MASTER_AND_SLAVE && !stateReg.delaysPresetFlag
			&& stateReg.presetTxDelay == `TP_DELAY_ZERO && stateReg.presetRxDelay == `TP_DELAY_ZERO
			&& stateReg.stateTimeout == `TP_DEF_STATE_TIMEOUT_MS && stateReg.stateRetryLimit == `TP_DEF_STATE_RETRY
			&& stateReg.calibrationPeriod == `TP_DEF_CAL_PERIOD_US
			&& stateReg.calibrationRetryLimit == `TP_DEF_CAL_RETRY))
		else $error("Static defaults did not reload.");

	// An error answer is only meaningful while the answer itself stands.
	chk_error_with_ready: assert property (pslverr |-> pready)
		else $error("Bus error raised without ready.");

endmodule : timing_port_dataset_store

/* File: protocol_engine_model.sv */
// Purpose: Behavioural protocol engine that reaches the dataset store over APB.
// Assumes: One clock; the bench starts each transfer through transfer().
// Notes: Released lines are inverted so a stale address or data never looks live.
module protocol_engine_model (
	// Clock.
	input wire logic mclk,
	// APB master side.
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// High once a transfer went unanswered.
	output logic hang
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus at time zero.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'hFF;
		pwdata = 32'h5A5A5A5A;
		hang = 1'b0;
	end

	// Setup, then access held until pready is sampled high; the wait is bounded.
	task automatic transfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		int waitCnt;
		rdata = 32'h0;
		err = 1'b1;
		waitCnt = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			waitCnt++;
		end while (pready !== 1'b1 && waitCnt < 20);
		if (pready === 1'b1) begin
			rdata = prdata;
			err = pslverr;
		end else begin
			hang = 1'b1;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~addr;
		pwdata <= ~wdata;
	endtask : transfer

endmodule : protocol_engine_model

/* File: test_timing_port_dataset_store.sv */
// Purpose: Self-checking bench of the port dataset store.
// Assumes: 100 MHz mclk; the engine model drives the APB side.
// Notes: Expected values come from the field definitions, never from the design.
`include "timing_port_map.svh"
module test_timing_port_dataset_store import timing_port_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk;
	logic rstn;
	logic psel, penable, pwrite, pready, pslverr, hang, roleActiveFlag;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0] currentPortRole;
	logic [3:0] linkSetupState;
	int errorCnt = 0;
	int cmpCount = 0;

	// Store under test and the engine that drives it.
	timing_port_dataset_store timing_port_dataset_store_i (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.currentPortRole(currentPortRole), .roleActiveFlag(roleActiveFlag), .linkSetupState(linkSetupState));
	protocol_engine_model protocol_engine_model_i (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hang(hang));

	// Free-running clock.
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Verdict, reached from the end of the sequence or from a hang.
	task automatic finishTest();
		if (errorCnt == 0 && cmpCount > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finishTest

	// Counted comparison.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			errorCnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// One transfer; an unanswered one ends the run at once.
	task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		protocol_engine_model_i.transfer(wr, addr, wdata, rdata, err);
		if (hang === 1'b1) begin
			errorCnt++;
			finishTest();
		end
	endtask : access

	task automatic writeReg(input logic [7:0] addr, input logic [31:0] data);
		logic [31:0] rd;
		logic err;
		access(1'b1, addr, data, rd, err);
	endtask : writeReg

	task automatic expectRead(input logic [7:0] addr, input logic [31:0] exp);
		logic [31:0] rd;
		logic err;
		access(1'b0, addr, 32'h0, rd, err);
		check(rd, exp);
	endtask : expectRead

	task automatic fire(input int bitPos);
		writeReg(`TP_OFF_EVENT, 32'h1 << bitPos);
	endtask : fire

	// Outputs are registered, so sample them half a cycle after the write lands.
	task automatic checkPorts(input port_role_e role, input logic active, input link_state_e state);
		@(negedge mclk);
		check({30'h0, currentPortRole}, {30'h0, role});
		check({31'h0, roleActiveFlag}, {31'h0, active});
		check({28'h0, linkSetupState}, {28'h0, state});
	endtask : checkPorts

	// Reset and default word of each offset.
	function automatic logic [31:0] resetValue(input logic [7:0] off);
		case (off)
			`TP_OFF_CONFIG: return {29'h0, 1'b0, CFG_MASTER_AND_SLAVE};
			`TP_OFF_STATE_TIMEOUT: return 32'h000003E8;
			`TP_OFF_STATE_RETRY: return 32'h00000003;
			`TP_OFF_CAL_PERIOD: return 32'h00000BB8;
			`TP_OFF_CAL_RETRY: return {24'h0, `TP_PORT_NUMBER + 8'h02};
			default: return 32'h0;
		endcase
	endfunction : resetValue

	task automatic dirtyDynamic();
		for (int off = 8'h30; off <= 8'h5C; off += 4) writeReg(8'(off), 32'hFFFFFFFF);
	endtask : dirtyDynamic

	// Dynamic fields back at their initial values, measured ones copied from the presets.
	task automatic expectRestored();
		expectRead(`TP_OFF_MEAS_TX_LO, 32'hCAFEF00D);
		expectRead(`TP_OFF_MEAS_RX_HI, 32'h9ABCDEF0);
		expectRead(`TP_OFF_FLAGS, 32'h00000008);
		for (int off = 8'h40; off <= 8'h54; off += 4) expectRead(8'(off), 32'h0);
		expectRead(`TP_OFF_PRIMARY, 32'h0);
	endtask : expectRestored

	// Widths and limits at their edges.
	task automatic fieldWidths();
		writeReg(`TP_OFF_PRESET_TX_HI, 32'hFFFFFFFF);
		expectRead(`TP_OFF_PRESET_TX_HI, 32'hFFFFFFFF);
		writeReg(`TP_OFF_PRESET_RX_LO, 32'hFFFFFFFF);
		writeReg(`TP_OFF_STATE_TIMEOUT, 32'hFFFFFFFF);
		expectRead(`TP_OFF_STATE_TIMEOUT, 32'hFFFFFFFF);
		writeReg(`TP_OFF_CAL_RETRY, 32'h00000021);
		expectRead(`TP_OFF_CAL_RETRY, 32'h00000020);
		writeReg(`TP_OFF_CAL_PERIOD, 32'hFFFFFFFF);
		expectRead(`TP_OFF_CAL_PERIOD, `TP_ANNOUNCE_INTERVAL_US - 32'h1);
		writeReg(`TP_OFF_STATE_RETRY, 32'h000001FF);
		expectRead(`TP_OFF_STATE_RETRY, 32'h000000FF);
		writeReg(`TP_OFF_PRIMARY, 32'h0001ABCD);
		expectRead(`TP_OFF_PRIMARY, 32'h0000ABCD);
	endtask : fieldWidths

	// Every role code is kept, ending away from the defaults, then the static defaults come back.
	task automatic staticDefaults();
		for (int c = 3; c >= 0; c--) begin
			writeReg(`TP_OFF_CONFIG, 32'(c) | 32'h00000004);
			expectRead(`TP_OFF_CONFIG, 32'(c) | 32'h00000004);
		end
		fire(`TP_EV_LOAD_DEFAULTS);
		for (int off = 0; off <= 8'h20; off += 4) expectRead(8'(off), resetValue(8'(off)));
	endtask : staticDefaults

	// Unmapped and misaligned accesses fail and change nothing.
	task automatic refusals();
		logic [31:0] rd;
		logic err;
		access(1'b0, 8'h64, 32'h0, rd, err);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		access(1'b1, 8'h01, 32'h0, rd, err);
		check({31'h0, err}, 32'h1);
		expectRead(`TP_OFF_CONFIG, {30'h0, CFG_MASTER_AND_SLAVE});
	endtask : refusals

	// Leaving idle restores the dynamic fields but keeps the current role.
	task automatic idleExit();
		writeReg(`TP_OFF_CONFIG, {29'h0, 1'b1, CFG_SLAVE_ONLY});
		writeReg(`TP_OFF_PRESET_TX_LO, 32'hCAFEF00D);
		writeReg(`TP_OFF_PRESET_RX_HI, 32'h9ABCDEF0);
		fire(`TP_EV_LINK_ON);
		writeReg(`TP_OFF_LINK_STATE, {28'h0, LS_IDLE});
		dirtyDynamic();
		writeReg(`TP_OFF_ROLE, {30'h0, ROLE_SLAVE});
		writeReg(`TP_OFF_LINK_STATE, {28'h0, LS_PRESENT});
		checkPorts(ROLE_SLAVE, 1'b0, LS_PRESENT);
		expectRead(`TP_OFF_STATUS, 32'h00000111);
		expectRestored();
	endtask : idleExit

	// Retries exhausted and re-initialisation restore every dynamic field, role included.
	// A completion straight out of idle then wipes the dynamic fields again.
	task automatic fullRestore();
		int evs[2] = '{`TP_EV_RETRIES, `TP_EV_REINIT};
		foreach (evs[i]) begin
			writeReg(`TP_OFF_ROLE, {30'h0, ROLE_MASTER});
			fire(`TP_EV_LINK_ON);
			dirtyDynamic();
			fire(evs[i]);
			checkPorts(ROLE_DISABLED, 1'b0, LS_IDLE);
			expectRestored();
			dirtyDynamic();
			fire(`TP_EV_LINK_ON);
			checkPorts(ROLE_DISABLED, 1'b1, LS_LINK_ON);
			expectRestored();
		end
	endtask : fullRestore

	// Completion raises the active flag; each clearing event acts on its own fields.
	task automatic roleEvents();
		int evs[4] = '{`TP_EV_MODE_OFF, `TP_EV_LEAVE_SLAVE, `TP_EV_LINK_LOST, `TP_EV_ANNOUNCE_TO};
		port_role_e roles[4] = '{ROLE_SLAVE, ROLE_SLAVE, ROLE_DISABLED, ROLE_DISABLED};
		logic actives[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
		foreach (evs[i]) begin
			writeReg(`TP_OFF_ROLE, {30'h0, ROLE_SLAVE});
			fire(`TP_EV_LINK_ON);
			checkPorts(ROLE_SLAVE, 1'b1, LS_LINK_ON);
			fire(evs[i]);
			checkPorts(roles[i], actives[i], LS_LINK_ON);
		end
		writeReg(`TP_OFF_ROLE, {30'h0, ROLE_MASTER});
		fire(`TP_EV_ANNOUNCE_TO);
		checkPorts(ROLE_MASTER, 1'b1, LS_LINK_ON);
	endtask : roleEvents

	// Main sequence.
	initial begin
		rstn = 1'b0;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		repeat (4) @(posedge mclk);
		checkPorts(ROLE_DISABLED, 1'b0, LS_IDLE);
		for (int off = 0; off <= 8'h60; off += 4) expectRead(8'(off), resetValue(8'(off)));
		fieldWidths();
		staticDefaults();
		refusals();
		idleExit();
		fullRestore();
		roleEvents();
		finishTest();
	end

endmodule : test_timing_port_dataset_store
